// *** rtl/lcmp_pkg.sv ***
// Package: register map, field layout and timing constants
//
// Function
// - Mask bit i enables channel i when it is one.
// - Mask readback shows zero for disabled or faulted channels.
// - Clearing then setting a faulted bit retries that channel only.
// - Reset loads the mask with 0x3f.
// - Drive strength code gives 25, 50, 75 or 100 percent.
// - Frequency bit one picks 1200 kHz, zero picks 600 kHz.
// - Short protect bit enables string short detection at 7.5 V.
// - Even phase mode spaces enabled channels by period over enabled count.
// - Step mode spaces enabled channels by step times period over 255.
// - Reset clears the phase register, so all channels start together.
package lcmp_pkg;
  localparam int NUM_CH = 6;
  localparam logic [7:0] ADDR_BOOST_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_CHANNEL_MASK = 8'h09;
  localparam logic [7:0] ADDR_PHASE_DELAY = 8'h0a;
  localparam logic [7:0] RST_BOOST_CONFIG = 8'h1f;
  localparam logic [7:0] RST_CHANNEL_MASK = 8'h3f;
  localparam logic [7:0] RST_PHASE_DELAY = 8'h00;
  localparam int POS_SHORT_PROTECT = 0;
  localparam int POS_FREQ_SELECT = 2;
  localparam int POS_DRIVE_LO = 4;
  localparam int POS_EVEN_PHASE = 7;
  localparam logic [7:0] MASK_CH_BITS = 8'h3f;
  localparam logic [7:0] PHASE_DIVISOR = 8'hff;
  localparam int FSW_HIGH_KHZ = 1200;
  localparam int FSW_LOW_KHZ = 600;
  localparam int SHORT_THRESH_MV = 7500;
  localparam int PERIOD_W = 16;
  typedef enum logic [1:0] {
    LCMP_DRV_25 = 2'h0,
    LCMP_DRV_50 = 2'h1,
    LCMP_DRV_75 = 2'h2,
    LCMP_DRV_100 = 2'h3
  } lcmp_drive_e;
endpackage

// *** rtl/lcmp_phase_calc.sv ***
// Per-channel start offset calculator for staggered PWM windows
`timescale 1ns/1ps
module lcmp_phase_calc
  import lcmp_pkg::*;
(
  input wire logic [5:0] chanActive,
  input wire logic evenPhaseSelect,
  input wire logic [6:0] phaseStepValue,
  input wire logic [PERIOD_W-1:0] pwmPeriod,
  output logic [6*PERIOD_W-1:0] chanOffset
);
  logic [PERIOD_W-1:0] spacing;
  logic [2:0] nEnabled;
  logic [PERIOD_W+7:0] prod;
  logic [PERIOD_W-1:0] acc;
  always_comb
  begin
    nEnabled = 3'h0;
    for (int i = 0; i < NUM_CH; i++)
      nEnabled = nEnabled + {2'h0, chanActive[i]};
    prod = pwmPeriod * {1'h0, phaseStepValue};
    if (evenPhaseSelect)
      spacing = (nEnabled == 3'h0) ? '0 :
        pwmPeriod / {{(PERIOD_W-3){1'b0}}, nEnabled};
    else
      spacing = PERIOD_W'(prod / PHASE_DIVISOR);
    acc = '0;
    chanOffset = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      // Disabled channels are skipped, so the chain stays tight
      chanOffset[i*PERIOD_W +: PERIOD_W] = acc;
      if (chanActive[i])
        acc = acc + spacing;
    end
  end
endmodule // lcmp_phase_calc

// *** rtl/lcmp_channel_ctrl.sv ***
// Channel mask, boost configuration and phase shift control top
`timescale 1ns/1ps
module lcmp_channel_ctrl
  import lcmp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic [5:0] chanFaultPin,
  input wire logic [PERIOD_W-1:0] pwmPeriod,
  output logic [5:0] chanRun,
  output logic [5:0] chanRestart,
  output logic [1:0] boostDriveStrength,
  output logic [6:0] driveStrengthPct,
  output logic switchingFreqSelect,
  output logic [10:0] switchFreqKhz,
  output logic shortProtectEnable,
  output logic [6*PERIOD_W-1:0] chanOffset
);
  typedef struct packed {
    logic [7:0] boostConfig;
    logic [7:0] chanMask;
    logic [7:0] phaseDelay;
    logic [5:0] faulted;
    logic [5:0] faultMeta;
    logic [5:0] faultSync;
    logic [5:0] restart;
    logic [7:0] rdData;
  } lcmp_state_s;
  lcmp_state_s st_r, st_nxt;
  logic [5:0] active;
  logic [1:0] drv;

  // Only enabled channels can latch a fault
  function automatic logic [5:0] newFaults(input lcmp_state_s s);
    return s.faultSync & s.chanMask[5:0];
  endfunction

  // Shared by readback and run outputs so they never disagree
  function automatic logic [5:0] visibleMask(input lcmp_state_s s);
    return s.chanMask[5:0] & ~s.faulted;
  endfunction

  // Fault pins come from analog comparators, so synchronise first
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.faultMeta = chanFaultPin;
    st_nxt.faultSync = st_r.faultMeta;
    st_nxt.restart = '0;
    // Latch faults on enabled channels; a channel stays off until retried
    st_nxt.faulted = st_r.faulted | newFaults(st_r);
    if (regWrEn)
    begin
      case (regAddr)
        ADDR_BOOST_CONFIG: st_nxt.boostConfig = regWrData;
        ADDR_CHANNEL_MASK:
        begin
          st_nxt.chanMask = regWrData & MASK_CH_BITS;
          // Clearing a bit drops its latched fault; new faults still win
          st_nxt.faulted = st_nxt.faulted &
            (regWrData[5:0] | newFaults(st_r));
          // Rising bit restarts only that channel
          st_nxt.restart = regWrData[5:0] & ~st_r.chanMask[5:0];
        end
        ADDR_PHASE_DELAY: st_nxt.phaseDelay = regWrData;
        default: ;
      endcase
    end
    if (regRdEn)
    begin
      case (regAddr)
        ADDR_BOOST_CONFIG: st_nxt.rdData = st_r.boostConfig;
        ADDR_CHANNEL_MASK:
          st_nxt.rdData = {2'h0, visibleMask(st_r)};
        ADDR_PHASE_DELAY: st_nxt.rdData = st_r.phaseDelay;
        default: st_nxt.rdData = 8'h00;
      endcase
    end
    if (srst)
    begin
      st_nxt = '0;
      st_nxt.boostConfig = RST_BOOST_CONFIG;
      st_nxt.chanMask = RST_CHANNEL_MASK;
      st_nxt.phaseDelay = RST_PHASE_DELAY;
    end
  end

  always_ff @(posedge clk)
  begin
    st_r <= st_nxt;
  end

  assign active = visibleMask(st_r);
  assign drv = st_r.boostConfig[POS_DRIVE_LO +: 2];

  always_comb
  begin
    case (lcmp_drive_e'(drv))
      LCMP_DRV_25: driveStrengthPct = 7'h19;
      LCMP_DRV_50: driveStrengthPct = 7'h32;
      LCMP_DRV_75: driveStrengthPct = 7'h4b;
      LCMP_DRV_100: driveStrengthPct = 7'h64;
      default: driveStrengthPct = 7'h64;
    endcase
  end

  assign regRdData = st_r.rdData;
  assign chanRun = active;
  assign chanRestart = st_r.restart;
  assign boostDriveStrength = drv;
  assign switchingFreqSelect = st_r.boostConfig[POS_FREQ_SELECT];
  assign switchFreqKhz = switchingFreqSelect ? 11'(FSW_HIGH_KHZ) :
    11'(FSW_LOW_KHZ);
  assign shortProtectEnable = st_r.boostConfig[POS_SHORT_PROTECT];

  // Host must keep total spread within one period; no wrap is applied
  lcmp_phase_calc u_phase (
    .chanActive(active),
    .evenPhaseSelect(st_r.phaseDelay[POS_EVEN_PHASE]),
    .phaseStepValue(st_r.phaseDelay[6:0]),
    .pwmPeriod(pwmPeriod),
    .chanOffset(chanOffset)
  );
endmodule // lcmp_channel_ctrl

// *** sim/lcmp_chk_assertions.sv ***
// Port checker for the channel control top
`timescale 1ns/1ps
module lcmp_chk
(
  input wire logic clk,
  input wire logic srst,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic [5:0] chanRun,
  input wire logic [5:0] chanRestart,
  input wire logic [1:0] boostDriveStrength,
  input wire logic [6:0] driveStrengthPct,
  input wire logic switchingFreqSelect,
  input wire logic shortProtectEnable,
  input wire logic [10:0] switchFreqKhz
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_mwr; regWrEn && regAddr == 8'h09; endsequence
  sequence s_mrd; regRdEn && regAddr == 8'h09; endsequence
  sequence s_cwr; regWrEn && regAddr == 8'h08; endsequence
  property p_drv; driveStrengthPct == 7'(25 * (boostDriveStrength + 1));
  endproperty
  a_drv: assert property (p_drv) else $error("drive pct");
  property p_fsw; switchFreqKhz == (switchingFreqSelect ? 11'h4b0 : 11'h258);
  endproperty
  a_fsw: assert property (p_fsw) else $error("freq khz");
  property p_cfg; s_cwr |=> shortProtectEnable == $past(regWrData[0])
    && switchingFreqSelect == $past(regWrData[2])
    && boostDriveStrength == $past(regWrData[5:4]); endproperty
  a_cfg: assert property (p_cfg) else $error("config");
  property p_rst; $fell(srst) |-> chanRun == 6'h3f && shortProtectEnable
    && switchingFreqSelect && boostDriveStrength == 2'h1; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_run; s_mwr |=> (chanRun & ~$past(regWrData[5:0])) == 6'h00;
  endproperty
  a_run: assert property (p_run) else $error("run");
  property p_rsa; chanRestart != 6'h00 |=>
    (chanRestart & $past(chanRestart)) == 6'h00; endproperty
  a_rsa: assert property (p_rsa) else $error("pulse");
  property p_rsb; chanRestart != 6'h00 |->
    $past(regWrEn) && $past(regAddr) == 8'h09; endproperty
  a_rsb: assert property (p_rsb) else $error("cause");
  property p_rdm; s_mrd |=> regRdData == {2'h0, $past(chanRun)}; endproperty
  a_rdm: assert property (p_rdm) else $error("readback");
endmodule // lcmp_chk

// *** sim/lcmp_host_model.sv ***
// Host model: one register byte per transfer
`timescale 1ns/1ps
module lcmp_host_model
(
  input wire logic clk,
  input wire logic [7:0] regRdData,
  output logic regWrEn = 1'h0,
  output logic regRdEn = 1'h0,
  output logic [7:0] regAddr = 8'h00,
  output logic [7:0] regWrData = 8'h00
);
  task automatic xfer(input logic w, input logic [7:0] a, d,
    output logic [7:0] q);
    @(negedge clk);
    {regWrEn, regRdEn, regAddr, regWrData} = {w, !w, a, d};
    @(negedge clk);
    {regWrEn, regRdEn} = 2'h0;
    // Idle bus inverted so stale values never look valid
    {regAddr, regWrData} = ~{a, d};
    q = regRdData;
  endtask
endmodule // lcmp_host_model

// *** sim/lcmp_channel_ctrl_tb_top.sv ***
// Testbench for the channel control top
`timescale 1ns/1ps
module lcmp_channel_ctrl_tb_top;
  import lcmp_pkg::*;
  logic clk = 1'h0, srst = 1'h1, wEn, rEn, fs, sp;
  logic [7:0] addr, wd, rd, q, x;
  logic [7:0] rv [4] = '{8'h1f, 8'h3f, 8'h00, 8'h00};
  logic [5:0] flt = 6'h00, run, rsr, m;
  logic [15:0] per = 16'h0100;
  logic [1:0] drv;
  logic [6:0] pct;
  logic [10:0] khz;
  logic [95:0] off, e;
  int bad_count = 0, tests_run = 0;
  lcmp_host_model host (.clk(clk), .regRdData(rd), .regWrEn(wEn),
    .regRdEn(rEn), .regAddr(addr), .regWrData(wd));
  lcmp_channel_ctrl uut (.clk(clk), .srst(srst), .regWrEn(wEn),
    .regRdEn(rEn), .regAddr(addr), .regWrData(wd), .regRdData(rd),
    .chanFaultPin(flt), .pwmPeriod(per), .chanRun(run), .chanRestart(rsr),
    .boostDriveStrength(drv), .driveStrengthPct(pct),
    .switchingFreqSelect(fs), .switchFreqKhz(khz),
    .shortProtectEnable(sp), .chanOffset(off));
  initial forever #50 clk = ~clk;
  task automatic chk(input logic [95:0] s, x);
    tests_run++;
    if (s !== x)
    begin
      bad_count++;
      $display("Error %0t: saw %h want %h", $time, s, x);
    end
  endtask
  function automatic logic [95:0] exp_off(logic [5:0] m, logic [7:0] p);
    logic [31:0] a, s;
    a = 0;
    s = p[7] ? ($countones(m) ? per / $countones(m) : 0) : per * p[6:0] / 255;
    exp_off = '0;
    for (int i = 0; i < 6; i++)
    begin
      exp_off[16*i+:16] = a[15:0];
      a += m[i] ? s : 0;
    end
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h7417af0f));
    repeat (8) @(negedge clk);
    srst = 1'h0;
    chk(off, 96'h0);
    for (int i = 0; i < 4; i++)
    begin
      host.xfer(1'h0, 8'h08 + 8'(i), 8'h00, q);
      chk(q, rv[i]);
    end
    $display("reset test done");
    for (int c = 0; c < 4; c++)
    begin
      x = 8'($urandom);
      x[5:4] = 2'(c);
      host.xfer(1'h1, 8'h08, x, q);
      chk(pct, 25 * (c + 1));
      chk(khz, x[2] ? 1200 : 600);
      chk(sp, x[0]);
      chk({fs, drv}, {x[2], x[5:4]});
      // Unmapped write must leave the config byte alone
      host.xfer(1'h1, 8'h0b, ~x, q);
      host.xfer(1'h0, 8'h08, 8'h00, q);
      chk(q, x);
    end
    $display("config test done");
    for (int k = 0; k < 30; k++)
    begin
      m = k == 0 ? 6'h21 : 6'($urandom);
      // Step capped so five gaps stay within one period
      x = k == 0 ? 8'h7f : {1'($urandom), 7'($urandom % 52)};
      per = 16'($urandom);
      host.xfer(1'h1, 8'h09, {2'h3, m}, q);
      host.xfer(1'h1, 8'h0a, x, q);
      host.xfer(1'h0, 8'h09, 8'h00, q);
      chk(q, {2'h0, m});
      e = exp_off(m, x);
      for (int i = 0; i < 6; i++)
        if (m[i]) chk(off[16*i+:16], e[16*i+:16]);
    end
    $display("phase test done");
    host.xfer(1'h1, 8'h09, 8'h3f, q);
    flt = 6'h04;
    repeat (4) @(negedge clk);
    chk(run, 6'h3b);
    host.xfer(1'h0, 8'h09, 8'h00, q);
    chk(q, 8'h3b);
    flt = 6'h00;
    repeat (4) @(negedge clk);
    host.xfer(1'h1, 8'h09, 8'h3b, q);
    chk(run, 6'h3b);
    host.xfer(1'h1, 8'h09, 8'h3f, q);
    chk({rsr, run}, 12'h13f);
    $display("fault test done");
    srst = 1'h1;
    repeat (2) @(negedge clk);
    srst = 1'h0;
    for (int i = 0; i < 3; i++)
    begin
      host.xfer(1'h0, 8'h08 + 8'(i), 8'h00, q);
      chk(q, rv[i]);
    end
    chk(off, 96'h0);
    $display("second reset test done");
    give_verdict();
  end
  initial
  begin
    #5000000;
    bad_count++;
    give_verdict();
  end
endmodule // lcmp_channel_ctrl_tb_top
bind lcmp_channel_ctrl lcmp_chk chk_i (.*);
